// ===== hw/ash_top.sv
// Local design decisions: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module ash_top #(
   parameter int UNIT_CYC = ash_pkg::UNIT_CYCLES
) (
   input  wire logic                                 aclk,
   input  wire logic                                 aresetn,
   input  wire logic [31:0]                          s_axi_awaddr,
   input  wire logic                                 s_axi_awvalid,
   output logic                                      s_axi_awready,
   input  wire logic [31:0]                          s_axi_wdata,
   input  wire logic [3:0]                           s_axi_wstrb,
   input  wire logic                                 s_axi_wvalid,
   output logic                                      s_axi_wready,
   output logic [1:0]                                s_axi_bresp,
   output logic                                      s_axi_bvalid,
   input  wire logic                                 s_axi_bready,
   input  wire logic [31:0]                          s_axi_araddr,
   input  wire logic                                 s_axi_arvalid,
   output logic                                      s_axi_arready,
   output logic [31:0]                               s_axi_rdata,
   output logic [1:0]                                s_axi_rresp,
   output logic                                      s_axi_rvalid,
   input  wire logic                                 s_axi_rready,
   input  wire logic [ash_pkg::NUM_AXES-1:0]         axis_motion_start_req,
   input  wire logic                                 host_ready_in,
   input  wire ash_pkg::ash_axis_evt_s               axis_evt_in [ash_pkg::NUM_AXES],
   output logic [ash_pkg::NUM_AXES-1:0]              axis_launch_out,
   output logic [ash_pkg::NUM_AXES-1:0]              axis_busy_out,
   output logic [ash_pkg::NUM_AXES-1:0]              axis_position_done_out,
   output logic [ash_pkg::NUM_AXES-1:0]              axis_fault_flag_out,
   output logic [ash_pkg::NUM_AXES-1:0]              axis_aux_code_set_out,
   output logic                                      irq_out
);
   import ash_pkg::*;

   logic                              aw_full_q;
   logic                              w_full_q;
   ash_wr_s                           wr_q;
   logic                              wr_fire;
   logic                              ar_fire;
   ash_aux_mode_e                     aux_mode_q;
   logic [HOLD_W-1:0]                 done_pulse_hold_time_q;
   logic [NUM_AXES-1:0]               aux_code_clear_request;
   logic [NUM_AXES-1:0]               error_reset_req;
   logic [NUM_AXES-1:0]               int_mask_warn_q;
   logic [NUM_AXES-1:0]               int_mask_err_q;
   logic [NUM_AXES-1:0]               int_warn_q;
   logic [NUM_AXES-1:0]               int_err_q;
   logic [NUM_AXES-1:0]               req_prev_q;
   logic [NUM_AXES-1:0]               req_rise;
   logic [NUM_AXES-1:0]               start_ok;
   logic [NUM_AXES-1:0]               any_start;
   logic [NUM_AXES-1:0]               valid_done;
   logic [NUM_AXES-1:0]               warn_evt;
   logic [NUM_AXES-1:0]               err_evt;
   logic [NUM_AXES-1:0]               aux_set_evt;
   logic [CODE_W-1:0]                 warn_code_d    [NUM_AXES];
   logic [CODE_W-1:0]                 err_code_d     [NUM_AXES];
   logic [CODE_W-1:0]                 warn_code_q    [NUM_AXES];
   logic [CODE_W-1:0]                 err_code_q     [NUM_AXES];
   logic [HOLD_W-1:0]                 hold_cnt_q     [NUM_AXES];
   logic [31:0]                       unit_cnt_q;
   logic                              unit_tick;
   logic [31:0]                       rd_d;
   logic [1:0]                        rresp_d;

   // Write channel: address and data are taken independently, answered once both are in.
   assign wr_fire = aw_full_q && w_full_q && !s_axi_bvalid;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_full_q     <= 1'b0;
         w_full_q      <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
         wr_q          <= '0;
      end
      else
      begin
         s_axi_awready <= !aw_full_q && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready  <= !w_full_q && !(s_axi_wvalid && s_axi_wready);
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_full_q <= 1'b1;
            wr_q.addr <= s_axi_awaddr[7:0];
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_full_q  <= 1'b1;
            wr_q.data <= s_axi_wdata;
            wr_q.strb <= s_axi_wstrb;
         end
         if (wr_fire)
         begin
            aw_full_q    <= 1'b0;
            w_full_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (wr_q.addr == REG_CTRL || wr_q.addr == REG_HOLD_TIME || wr_q.addr == REG_COMMAND ||
                wr_q.addr == REG_INT_STAT || wr_q.addr == REG_INT_MASK)
               s_axi_bresp <= RESP_OKAY;
            else
               s_axi_bresp <= RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // Control registers written by software.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aux_mode_q             <= AUX_AT_START;
         done_pulse_hold_time_q <= HOLD_RESET;
         int_mask_warn_q        <= '0;
         int_mask_err_q         <= '0;
      end
      else if (wr_fire && wr_q.strb[0])
      begin
         if (wr_q.addr == REG_CTRL)
            aux_mode_q <= ash_aux_mode_e'(wr_q.data[CTRL_MODE_BIT]);
         else if (wr_q.addr == REG_HOLD_TIME)
            done_pulse_hold_time_q <= wr_q.data[HOLD_W-1:0];
         else if (wr_q.addr == REG_INT_MASK)
         begin
            int_mask_warn_q <= wr_q.data[INT_WARN_LSB +: NUM_AXES];
            int_mask_err_q  <= wr_q.data[INT_ERR_LSB +: NUM_AXES];
         end
      end
   end

   // Command register bits act for one cycle and are never stored.
   always_comb
   begin
      aux_code_clear_request = '0;
      error_reset_req        = '0;
      if (wr_fire && wr_q.strb[0] && wr_q.addr == REG_COMMAND)
      begin
         aux_code_clear_request = wr_q.data[CMD_CLR_LSB +: NUM_AXES];
         error_reset_req        = wr_q.data[CMD_ERST_LSB +: NUM_AXES];
      end
   end

   // Read channel.
   assign ar_fire = s_axi_arvalid && s_axi_arready;

   always_comb
   begin
      rd_d    = DATA_ZERO;
      rresp_d = RESP_OKAY;
      if (s_axi_araddr[7:0] == REG_CTRL)
         rd_d[CTRL_MODE_BIT] = aux_mode_q;
      else if (s_axi_araddr[7:0] == REG_HOLD_TIME)
         rd_d[HOLD_W-1:0] = done_pulse_hold_time_q;
      else if (s_axi_araddr[7:0] == REG_COMMAND)
         rd_d = DATA_ZERO;
      else if (s_axi_araddr[7:0] == REG_STATUS)
      begin
         rd_d[ST_DONE_LSB +: NUM_AXES]  = axis_position_done_out;
         rd_d[ST_FAULT_LSB +: NUM_AXES] = axis_fault_flag_out;
         rd_d[ST_AUX_LSB +: NUM_AXES]   = axis_aux_code_set_out;
         rd_d[ST_BUSY_LSB +: NUM_AXES]  = axis_busy_out;
      end
      else if (s_axi_araddr[7:0] == REG_INT_STAT)
      begin
         rd_d[INT_WARN_LSB +: NUM_AXES] = int_warn_q;
         rd_d[INT_ERR_LSB +: NUM_AXES]  = int_err_q;
      end
      else if (s_axi_araddr[7:0] == REG_INT_MASK)
      begin
         rd_d[INT_WARN_LSB +: NUM_AXES] = int_mask_warn_q;
         rd_d[INT_ERR_LSB +: NUM_AXES]  = int_mask_err_q;
      end
      else if (s_axi_araddr[7:0] == REG_CODE_BASE)
         rd_d = {warn_code_q[0], err_code_q[0]};
      else if (s_axi_araddr[7:0] == REG_CODE_BASE + 8'h04)
         rd_d = {warn_code_q[1], err_code_q[1]};
      else if (s_axi_araddr[7:0] == REG_CODE_BASE + 8'h08)
         rd_d = {warn_code_q[2], err_code_q[2]};
      else
         rresp_d = RESP_SLVERR;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= DATA_ZERO;
         s_axi_rresp   <= RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= !s_axi_rvalid && !ar_fire;
         if (ar_fire)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_d;
            s_axi_rresp  <= rresp_d;
         end
         else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   // One shared millisecond tick; the hold time therefore ends up to one tick early at most.
   assign unit_tick = (unit_cnt_q == 32'(UNIT_CYC - 1));

   always_ff @(posedge aclk)
   begin
      if (!aresetn || unit_tick)
         unit_cnt_q <= DATA_ZERO;
      else
         unit_cnt_q <= unit_cnt_q + 32'h0000_0001;
   end

   // Per-axis event decoding; each axis reads only its own inputs and the shared host_ready_in.
   always_comb
   begin
      for (int i = 0; i < NUM_AXES; i++)
      begin
         req_rise[i]    = axis_motion_start_req[i] && !req_prev_q[i];
         start_ok[i]    = req_rise[i] && !axis_busy_out[i] && !axis_aux_code_set_out[i] && host_ready_in;
         any_start[i]   = start_ok[i] || axis_evt_in[i].manual_start;
         // Completion is the end of command output alone; no in-position check.
         valid_done[i]  = axis_evt_in[i].entry_done && !axis_evt_in[i].speed_ctrl
                          && !axis_evt_in[i].cancelled;
         aux_set_evt[i] = (axis_evt_in[i].aux_code_value != CODE_NONE)
                          && ((aux_mode_q == AUX_AT_START && axis_evt_in[i].entry_start)
                              || (aux_mode_q == AUX_AT_DONE && valid_done[i]));
         warn_evt[i]    = 1'b0;
         warn_code_d[i] = warn_code_q[i];
         err_evt[i]     = axis_evt_in[i].error;
         err_code_d[i]  = axis_evt_in[i].error ? axis_evt_in[i].error_code : err_code_q[i];
         if (req_rise[i] && axis_busy_out[i])
         begin
            warn_evt[i]    = 1'b1;
            warn_code_d[i] = WARN_START_BUSY;
         end
         else if (axis_evt_in[i].entry_start && axis_evt_in[i].continuous && axis_aux_code_set_out[i])
         begin
            warn_evt[i]    = 1'b1;
            warn_code_d[i] = WARN_AUX_PATH;
         end
         if ((req_rise[i] && !axis_busy_out[i] || axis_evt_in[i].manual_start) && axis_aux_code_set_out[i])
         begin
            err_evt[i]     = 1'b1;
            err_code_d[i]  = ERR_AUX_START;
         end
      end
   end

   // Per-axis status flags.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         req_prev_q             <= '0;
         axis_launch_out        <= '0;
         axis_busy_out          <= '0;
         axis_position_done_out <= '0;
         axis_fault_flag_out    <= '0;
         axis_aux_code_set_out  <= '0;
         for (int i = 0; i < NUM_AXES; i++)
         begin
            hold_cnt_q[i]  <= HOLD_RESET;
            warn_code_q[i] <= CODE_NONE;
            err_code_q[i]  <= CODE_NONE;
         end
      end
      else
      begin
         req_prev_q      <= axis_motion_start_req;
         axis_launch_out <= start_ok;
         for (int i = 0; i < NUM_AXES; i++)
         begin
            warn_code_q[i] <= warn_code_d[i];
            err_code_q[i]  <= error_reset_req[i] && !err_evt[i] ? CODE_NONE : err_code_d[i];
            // Busy rises on a start and falls on idle; a zero-travel run holds busy until its idle event.
            if (any_start[i])
               axis_busy_out[i] <= 1'b1;
            else if (axis_evt_in[i].idle)
               axis_busy_out[i] <= 1'b0;
            if (any_start[i])
            begin
               axis_position_done_out[i] <= 1'b0;
               hold_cnt_q[i]             <= HOLD_RESET;
            end
            else if (valid_done[i] && done_pulse_hold_time_q != HOLD_RESET)
            begin
               axis_position_done_out[i] <= 1'b1;
               hold_cnt_q[i]             <= done_pulse_hold_time_q;
            end
            else if (unit_tick && hold_cnt_q[i] != HOLD_RESET)
            begin
               hold_cnt_q[i] <= hold_cnt_q[i] - 16'h0001;
               if (hold_cnt_q[i] == 16'h0001)
                  axis_position_done_out[i] <= 1'b0;
            end
            if (err_evt[i])
               axis_fault_flag_out[i] <= 1'b1;
            else if (error_reset_req[i])
               axis_fault_flag_out[i] <= 1'b0;
            // Losing host-ready wins over a set in the same cycle.
            if (!host_ready_in)
               axis_aux_code_set_out[i] <= 1'b0;
            else if (aux_set_evt[i])
               axis_aux_code_set_out[i] <= 1'b1;
            else if (aux_code_clear_request[i])
               axis_aux_code_set_out[i] <= 1'b0;
         end
      end
   end

   // Sticky interrupt status, cleared by writing ones; a new event beats the clear.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         int_warn_q <= '0;
         int_err_q  <= '0;
         irq_out    <= 1'b0;
      end
      else
      begin
         for (int i = 0; i < NUM_AXES; i++)
         begin
            if (warn_evt[i])
               int_warn_q[i] <= 1'b1;
            else if (wr_fire && wr_q.strb[0] && wr_q.addr == REG_INT_STAT && wr_q.data[INT_WARN_LSB + i])
               int_warn_q[i] <= 1'b0;
            if (err_evt[i])
               int_err_q[i] <= 1'b1;
            else if (wr_fire && wr_q.strb[0] && wr_q.addr == REG_INT_STAT && wr_q.data[INT_ERR_LSB + i])
               int_err_q[i] <= 1'b0;
         end
         irq_out <= |(int_warn_q & int_mask_warn_q) || |(int_err_q & int_mask_err_q);
      end
   end

endmodule : ash_top

// ===== hw/ash_pkg.sv
package ash_pkg;

   localparam int          NUM_AXES       = 3;
   localparam int          CODE_W         = 16;
   localparam int          HOLD_W         = 16;

   // Register byte offsets.
   localparam logic [7:0]  REG_CTRL       = 8'h00;
   localparam logic [7:0]  REG_HOLD_TIME  = 8'h04;
   localparam logic [7:0]  REG_COMMAND    = 8'h08;
   localparam logic [7:0]  REG_STATUS     = 8'h0C;
   localparam logic [7:0]  REG_INT_STAT   = 8'h10;
   localparam logic [7:0]  REG_INT_MASK   = 8'h14;
   localparam logic [7:0]  REG_CODE_BASE  = 8'h20;

   // Field positions.
   localparam int          CTRL_MODE_BIT  = 0;
   localparam int          CMD_CLR_LSB    = 0;
   localparam int          CMD_ERST_LSB   = 4;
   localparam int          ST_DONE_LSB    = 0;
   localparam int          ST_FAULT_LSB   = 4;
   localparam int          ST_AUX_LSB     = 8;
   localparam int          ST_BUSY_LSB    = 12;
   localparam int          INT_WARN_LSB   = 0;
   localparam int          INT_ERR_LSB    = 4;
   localparam int          CODE_WARN_LSB  = 16;

   // Reset values.
   localparam logic [HOLD_W-1:0] HOLD_RESET = 16'h0000;
   localparam logic [31:0]       DATA_ZERO  = 32'h0000_0000;

   // Warning and error codes.
   localparam logic [CODE_W-1:0] WARN_START_BUSY = 16'd100;
   localparam logic [CODE_W-1:0] WARN_AUX_PATH   = 16'd503;
   localparam logic [CODE_W-1:0] ERR_AUX_START   = 16'd536;
   localparam logic [CODE_W-1:0] CODE_NONE       = 16'h0000;

   // Hold time unit is one millisecond.
   localparam int          CLK_PERIOD_NS  = 8;
   localparam int          HOLD_UNIT_NS   = 1000000;
   localparam int          UNIT_CYCLES    = HOLD_UNIT_NS / CLK_PERIOD_NS;

   localparam logic [1:0]  RESP_OKAY      = 2'b00;
   localparam logic [1:0]  RESP_SLVERR    = 2'b10;

   typedef enum logic {
      AUX_AT_START,
      AUX_AT_DONE
   } ash_aux_mode_e;

   // Events reported by the motion engine of one axis.
   typedef struct packed {
      logic              entry_start;
      logic              entry_done;
      logic              speed_ctrl;
      logic              cancelled;
      logic              manual_start;
      logic              continuous;
      logic              idle;
      logic              error;
      logic [CODE_W-1:0] error_code;
      logic [CODE_W-1:0] aux_code_value;
   } ash_axis_evt_s;

   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] data;
      logic [3:0]  strb;
   } ash_wr_s;

endpackage : ash_pkg

// ===== bench/ash_properties.sv
`timescale 1ns/1ps
module ash_properties #(
   parameter int UNIT_CYC = 10
) (
   input wire logic                            aclk,
   input wire logic                            aresetn,
   input wire logic [ash_pkg::NUM_AXES-1:0]    axis_motion_start_req,
   input wire logic                            host_ready_in,
   input wire ash_pkg::ash_axis_evt_s          axis_evt_in [ash_pkg::NUM_AXES],
   input wire logic [ash_pkg::NUM_AXES-1:0]    axis_launch_out,
   input wire logic [ash_pkg::NUM_AXES-1:0]    axis_busy_out,
   input wire logic [ash_pkg::NUM_AXES-1:0]    axis_position_done_out,
   input wire logic [ash_pkg::NUM_AXES-1:0]    axis_fault_flag_out,
   input wire logic [ash_pkg::NUM_AXES-1:0]    axis_aux_code_set_out
);
   import ash_pkg::*;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   sequence s_accept;
      $rose(axis_motion_start_req[0]) && !axis_busy_out[0] && !axis_aux_code_set_out[0] && host_ready_in;
   endsequence
   sequence s_launch;
      axis_launch_out[0] && axis_busy_out[0] && !axis_position_done_out[0] ##1 !axis_launch_out[0];
   endsequence
   chk_start_launch: assert property (s_accept |=> s_launch)
      else $error("accepted start gave no launch pulse");
   chk_edge_only: assert property (axis_launch_out[0] |-> $past(axis_motion_start_req[0])
      && !$past(axis_motion_start_req[0], 2))
      else $error("launch without a rising start request");
   chk_busy_warn: assert property ($rose(axis_motion_start_req[0]) && axis_busy_out[0] |=> !axis_launch_out[0])
      else $error("start while busy launched");
   chk_aux_start_err: assert property ($rose(axis_motion_start_req[0]) && axis_aux_code_set_out[0]
      && !axis_busy_out[0] && host_ready_in |=> axis_fault_flag_out[0] && !axis_launch_out[0])
      else $error("start with aux flag set not refused");
   chk_no_done_abort: assert property (axis_evt_in[0].entry_done && (axis_evt_in[0].speed_ctrl
      || axis_evt_in[0].cancelled) && !axis_position_done_out[0] |=> !axis_position_done_out[0])
      else $error("done raised after speed control or cancel");
   chk_fault_set: assert property (axis_evt_in[0].error |=> axis_fault_flag_out[0])
      else $error("fault flag not set on error");
   chk_aux_ready_drop: assert property (!host_ready_in |=> axis_aux_code_set_out == '0)
      else $error("aux flag survived host ready low");
   chk_aux_zero_code: assert property (axis_evt_in[0].entry_start && axis_evt_in[0].aux_code_value == '0
      && !axis_aux_code_set_out[0] |=> !axis_aux_code_set_out[0])
      else $error("aux flag set for zero code");
   chk_axis_indep: assert property (axis_launch_out[1] |-> $past(axis_motion_start_req[1]))
      else $error("axis two launched without its own request");
   chk_manual_drop: assert property (axis_evt_in[0].manual_start |=> !axis_position_done_out[0])
      else $error("done kept after manual start");
endmodule : ash_properties

// ===== bench/ash_host_model.sv
`timescale 1ns/1ps
module ash_host_model (
   input  wire logic                         aclk,
   input  wire logic                         aresetn,
   input  wire logic [ash_pkg::NUM_AXES-1:0] go,
   output logic [ash_pkg::NUM_AXES-1:0]      axis_motion_start_req
);
   import ash_pkg::*;
   logic [3:0] hold_q [NUM_AXES];
   // The request stands four cycles and then drops, so the next request makes a fresh edge.
   always_ff @(posedge aclk)
   begin
      for (int a = 0; a < NUM_AXES; a++)
      begin
         hold_q[a] <= aresetn ? {hold_q[a][2:0], go[a]} : 4'h0;
      end
   end
   always_comb
   begin
      for (int a = 0; a < NUM_AXES; a++)
      begin
         axis_motion_start_req[a] = |hold_q[a];
      end
   end
endmodule : ash_host_model

// ===== bench/tb_axis_status_handshake.sv
`timescale 1ns/1ps
module tb_axis_status_handshake;
   import ash_pkg::*;
   logic          aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic          s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, host_ready_in, irq_out;
   logic [31:0]   s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rdv;
   logic [3:0]    s_axi_wstrb;
   logic [1:0]    s_axi_bresp, s_axi_rresp;
   logic [2:0]    go, axis_motion_start_req, axis_launch_out, axis_busy_out;
   logic [2:0]    axis_position_done_out, axis_fault_flag_out, axis_aux_code_set_out;
   ash_axis_evt_s axis_evt_in [NUM_AXES];
   int            miscompares, tests_run;

   ash_top #(.UNIT_CYC(10)) u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .axis_motion_start_req, .host_ready_in, .axis_evt_in, .axis_launch_out, .axis_busy_out,
      .axis_position_done_out, .axis_fault_flag_out, .axis_aux_code_set_out, .irq_out);
   ash_host_model u_host (.aclk, .aresetn, .go, .axis_motion_start_req);

   initial
   begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end

   task automatic final_report;
      $display("Counts: %0d checks, %0d mismatches", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : final_report

   task automatic cmp_word(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e)
      begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp_word

   task automatic cmp_bit(input string nm, input logic e, input logic g);
      cmp_word(nm, 32'(e), 32'(g));
   endtask : cmp_bit

   task automatic tk(input int n);
      repeat (n) @(posedge aclk);
   endtask : tk

   task automatic wr32(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic pa;
      logic pw;
      pa = 1'b1;
      pw = 1'b1;
      s_axi_awaddr  <= {24'h00_0000, a};
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      while (pa || pw)
      begin
         @(posedge aclk);
         pa = pa && (s_axi_awready !== 1'b1);
         pw = pw && (s_axi_wready !== 1'b1);
         if (!pa) s_axi_awvalid <= 1'b0;
         if (!pw) s_axi_wvalid <= 1'b0;
      end
      while (s_axi_bvalid !== 1'b1) @(posedge aclk);
      cmp_word("bresp", 32'(er), 32'(s_axi_bresp));
   endtask : wr32

   task automatic rd32(input logic [7:0] a, input logic [1:0] er);
      s_axi_araddr  <= {24'h00_0000, a};
      s_axi_arvalid <= 1'b1;
      @(posedge aclk);
      while (s_axi_arready !== 1'b1) @(posedge aclk);
      s_axi_arvalid <= 1'b0;
      @(posedge aclk);
      while (s_axi_rvalid !== 1'b1) @(posedge aclk);
      rdv = s_axi_rdata;
      cmp_word("rresp", 32'(er), 32'(s_axi_rresp));
   endtask : rd32

   task automatic strt(input int a);
      tk(3);
      go[a] <= 1'b1;
      tk(1);
      go <= '0;
      tk(2);
   endtask : strt

   task automatic ev(input int a, input ash_axis_evt_s e);
      axis_evt_in[a] <= e;
      tk(1);
      axis_evt_in[a] <= '0;
      tk(1);
   endtask : ev

   task automatic t_regs;
      rd32(REG_HOLD_TIME, RESP_OKAY);
      cmp_word("hold reset", 32'(HOLD_RESET), rdv);
      rd32(REG_COMMAND, RESP_OKAY);
      cmp_word("command read", DATA_ZERO, rdv);
      rd32(8'h40, RESP_SLVERR);
      wr32(REG_STATUS, 32'h0000_0001, RESP_SLVERR);
      $display("register test finished");
   endtask : t_regs

   task automatic t_done;
      wr32(REG_HOLD_TIME, 32'h0000_0002, RESP_OKAY);
      strt(0);
      cmp_bit("launch", 1'b1, axis_launch_out[0]);
      ev(0, '{entry_done: 1'b1, default: '0});
      cmp_bit("done set", 1'b1, axis_position_done_out[0]);
      ev(0, '{idle: 1'b1, default: '0});
      tk(5);
      cmp_bit("done held", 1'b1, axis_position_done_out[0]);
      tk(20);
      cmp_bit("done end", 1'b0, axis_position_done_out[0]);
      ev(0, '{entry_done: 1'b1, speed_ctrl: 1'b1, default: '0});
      cmp_bit("done speed", 1'b0, axis_position_done_out[0]);
      ev(0, '{entry_done: 1'b1, cancelled: 1'b1, default: '0});
      cmp_bit("done cancel", 1'b0, axis_position_done_out[0]);
      ev(0, '{entry_done: 1'b1, default: '0});
      strt(0);
      cmp_bit("done start", 1'b0, axis_position_done_out[0]);
      ev(0, '{entry_done: 1'b1, default: '0});
      ev(0, '{manual_start: 1'b1, default: '0});
      cmp_bit("done manual", 1'b0, axis_position_done_out[0]);
      ev(0, '{idle: 1'b1, default: '0});
      wr32(REG_HOLD_TIME, DATA_ZERO, RESP_OKAY);
      ev(0, '{entry_done: 1'b1, default: '0});
      cmp_bit("done zero hold", 1'b0, axis_position_done_out[0]);
      $display("done test finished");
   endtask : t_done

   task automatic t_warn;
      wr32(REG_INT_MASK, 32'h0000_0001, RESP_OKAY);
      strt(0);
      strt(0);
      cmp_bit("busy start", 1'b0, axis_launch_out[0]);
      rd32(REG_CODE_BASE, RESP_OKAY);
      cmp_word("busy code", 32'(WARN_START_BUSY), 32'(rdv[31:16]));
      cmp_bit("irq on", 1'b1, irq_out);
      wr32(REG_INT_STAT, 32'h0000_0001, RESP_OKAY);
      tk(2);
      cmp_bit("irq off", 1'b0, irq_out);
      wr32(REG_INT_MASK, DATA_ZERO, RESP_OKAY);
      strt(0);
      tk(2);
      cmp_bit("irq masked", 1'b0, irq_out);
      rd32(REG_INT_STAT, RESP_OKAY);
      cmp_word("warn status", 32'h0000_0001, rdv);
      wr32(REG_INT_STAT, 32'h0000_0001, RESP_OKAY);
      ev(0, '{idle: 1'b1, default: '0});
      $display("warning test finished");
   endtask : t_warn

   task automatic t_aux;
      wr32(REG_CTRL, DATA_ZERO, RESP_OKAY);
      ev(0, '{entry_start: 1'b1, aux_code_value: 16'h0005, default: '0});
      cmp_bit("aux at start", 1'b1, axis_aux_code_set_out[0]);
      ev(0, '{entry_start: 1'b1, continuous: 1'b1, aux_code_value: 16'h0005, default: '0});
      rd32(REG_CODE_BASE, RESP_OKAY);
      cmp_word("path code", 32'(WARN_AUX_PATH), 32'(rdv[31:16]));
      strt(0);
      cmp_bit("aux start", 1'b0, axis_launch_out[0]);
      cmp_bit("aux fault", 1'b1, axis_fault_flag_out[0]);
      rd32(REG_CODE_BASE, RESP_OKAY);
      cmp_word("error code", 32'(ERR_AUX_START), 32'(rdv[15:0]));
      wr32(REG_COMMAND, 32'h0000_0001, RESP_OKAY);
      tk(2);
      cmp_bit("aux clear", 1'b0, axis_aux_code_set_out[0]);
      wr32(REG_COMMAND, 32'h0000_0010, RESP_OKAY);
      tk(2);
      cmp_bit("fault reset", 1'b0, axis_fault_flag_out[0]);
      ev(0, '{entry_start: 1'b1, default: '0});
      cmp_bit("aux zero", 1'b0, axis_aux_code_set_out[0]);
      wr32(REG_CTRL, 32'h0000_0001, RESP_OKAY);
      ev(0, '{entry_start: 1'b1, aux_code_value: 16'h0005, default: '0});
      cmp_bit("aux mode one start", 1'b0, axis_aux_code_set_out[0]);
      ev(0, '{entry_done: 1'b1, aux_code_value: 16'h0007, default: '0});
      cmp_bit("aux at done", 1'b1, axis_aux_code_set_out[0]);
      host_ready_in <= 1'b0;
      tk(2);
      cmp_bit("aux ready drop", 1'b0, axis_aux_code_set_out[0]);
      host_ready_in <= 1'b1;
      ev(0, '{error: 1'b1, error_code: 16'h0001, default: '0});
      tk(4);
      cmp_bit("fault sticky", 1'b1, axis_fault_flag_out[0]);
      wr32(REG_COMMAND, 32'h0000_0010, RESP_OKAY);
      tk(2);
      cmp_bit("fault cleared", 1'b0, axis_fault_flag_out[0]);
      $display("aux test finished");
   endtask : t_aux

   task automatic t_axis;
      strt(1);
      cmp_bit("axis two launch", 1'b1, axis_launch_out[1]);
      cmp_word("other launch", DATA_ZERO, 32'(axis_launch_out & 3'h5));
      cmp_bit("zero move busy", 1'b1, axis_busy_out[1]);
      ev(1, '{idle: 1'b1, default: '0});
      cmp_bit("zero move idle", 1'b0, axis_busy_out[1]);
      $display("axis test finished");
   endtask : t_axis

   initial
   begin
      #200000;
      miscompares++;
      final_report();
   end

   initial
   begin
      aresetn = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
      // Response readies stay high, so back-to-back transfers never drive them twice in one step.
      {s_axi_bready, s_axi_rready} = 2'b11;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
      s_axi_wstrb = 4'hf;
      host_ready_in = 1'b1;
      go = '0;
      axis_evt_in = '{default: '0};
      miscompares = 0;
      tests_run = 0;
      tk(6);
      aresetn <= 1'b1;
      t_regs();
      t_done();
      t_warn();
      t_aux();
      t_axis();
      final_report();
   end
endmodule : tb_axis_status_handshake

bind ash_top ash_properties #(.UNIT_CYC(UNIT_CYC)) u_chk (.aclk, .aresetn, .axis_motion_start_req,
   .host_ready_in, .axis_evt_in, .axis_launch_out, .axis_busy_out, .axis_position_done_out,
   .axis_fault_flag_out, .axis_aux_code_set_out);
